// File: core/pscr_regs.sv
// Top: serially loaded control bank with readback and output gating
`timescale 1ns/1ps
import pscr_pkg::*;
// Summary of operation
// - Divisor field accepts 9..4104; usable operating range is 256..4096.
// - Post-divider field divides oscillator output by 1, 2, 4 or 8.
// - Coarse delay code 00..11 gives 2..5 clocks of sync delay.
// - Fine delay code 0..63 adds (code+1)/32 of a clock.
// - Two-bit pump code selects about 100, 200, 400 or 800 uA.
// - Polarity bits for sync, delayed sync, detector: 1 positive, 0 negative.
// - Readback enable shifts register contents out on the readback line.
// - Chip enable bit switches the whole synthesizer on or off.
// - Cleared bypass bit routes the counter test path to the full-rate clocks instead of oscillator.
// - Each logic-level output has its own enable bit.
// - Tap routed to delayed sync is delayed 4 clocks, or 5 when set.
// - Tap pulse width code 00..11 gives 1, 2, 4 or 8 clocks.
// - During coast, hold bit off fixes output by polarity; on passes signal.
// - Source bit on selects delayed sync, off selects counter tap.
// - Readback returns exactly the seven registers' written values.
// - Coast input is active high.
// - Differential outputs always driven; logic outputs only when enabled.
module pscr_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Three-wire serial bus
  input wire logic serial_clk,
  input wire logic serial_in_bit,
  input wire logic load_window,
  output logic readback_line,
  output logic readback_line_oe_n,
  // Sync and test inputs
  input wire logic sync_in,
  input wire logic counter_tap_in,
  input wire logic coast,
  input wire logic lock_loss_in,
  input wire logic full_rate_clk_in,
  input wire logic half_rate_clk_in,
  // Decoded analog controls
  output logic [12:0] divisor_value,
  output logic [3:0] post_div_ratio,
  output logic [6:0] fine_delay_32nds,
  output logic [1:0] pump_current_code,
  output logic phase_detector_sense,
  output logic chip_enable_bit,
  output logic oscillator_bypass_bit,
  output logic divisor_in_range,
  // Logic-level outputs with enables, low enable drives
  output logic counter_tap_out,
  output logic counter_tap_out_oe_n,
  output logic lock_loss_out,
  output logic lock_loss_out_oe_n,
  output logic delayed_hsync_out,
  output logic delayed_hsync_out_oe_n,
  output logic half_rate_clock_out,
  output logic half_rate_clock_out_oe_n,
  output logic half_rate_clock_out_inv,
  output logic half_rate_clock_out_inv_oe_n,
  output logic full_rate_clock_out,
  output logic full_rate_clock_out_oe_n,
  output logic full_rate_clock_out_inv,
  output logic full_rate_clock_out_inv_oe_n,
  // Differential outputs, always driven
  output logic diff_full_rate_p,
  output logic diff_full_rate_n,
  output logic diff_half_rate_p,
  output logic diff_half_rate_n,
  output logic diff_delayed_hsync_out_p,
  output logic diff_delayed_hsync_out_n
);
  import pscr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [4:0] meta;
    logic [4:0] sync2;
    logic sclk_d;
    logic win_d;
    logic [PSCR_TOTAL_BITS-1:0] shift;
    logic [PSCR_TOTAL_BITS-1:0] regs;
    logic [PSCR_TOTAL_BITS-1:0] rb_shift;
    logic rb_bit;
    logic [6:0] meta_b;
    logic [6:0] sync_b;
  } pscr_top_t;
  pscr_top_t st_q, st_d;

  function automatic logic [12:0] div_decode(
    input logic [PSCR_TOTAL_BITS-1:0] r);
    logic [11:0] raw;
    raw = {r[P_DIV_A +: W_DIV_A], r[P_DIV_B +: W_DIV_B]};
    div_decode = {1'b0, raw} + 13'(DIV_OFFSET);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised pins
  logic sclk_s, sdin_s, win_s, coast_s, sync_s, tap_s;
  logic lock_s, full_s, half_s;
  assign sclk_s = st_q.sync2[0];
  assign sdin_s = st_q.sync2[1];
  assign win_s = st_q.sync2[2];
  assign coast_s = st_q.sync2[3];
  assign sync_s = st_q.sync2[4];
  assign tap_s = st_q.sync_b[0];
  assign lock_s = st_q.sync_b[1];
  // Clock pins are only sampled; real chips bypass this path
  assign full_s = st_q.sync_b[2];
  assign half_s = st_q.sync_b[3];

  logic sclk_rise;
  logic [W_DELAY-1:0] delay_r;
  logic [W_PUMP-1:0] pump_r;
  logic [W_OEPOL-1:0] oe_r;
  logic [W_TESTPOW-1:0] tp_r;
  assign delay_r = st_q.regs[P_DELAY +: W_DELAY];
  assign pump_r = st_q.regs[P_PUMP +: W_PUMP];
  assign oe_r = st_q.regs[P_OEPOL +: W_OEPOL];
  assign tp_r = st_q.regs[P_TESTPOW +: W_TESTPOW];
  assign sclk_rise = sclk_s & ~st_q.sclk_d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    st_d.meta = {sync_in, coast, load_window, serial_in_bit, serial_clk};
    st_d.sync2 = st_q.meta;
    st_d.meta_b = {3'h0, half_rate_clk_in, full_rate_clk_in,
      lock_loss_in, counter_tap_in};
    st_d.sync_b = st_q.meta_b;
    st_d.sclk_d = sclk_s;
    st_d.win_d = win_s;
    if (win_s && sclk_rise) begin
      // MSB first; last 42 bits shifted win
      st_d.shift = {st_q.shift[PSCR_TOTAL_BITS-2:0], sdin_s};
    end
    if (st_q.win_d && !win_s) begin
      st_d.regs = st_q.shift;
      st_d.rb_shift = st_q.shift;
    end else if (tp_r[F_SCAN] && !win_s && sclk_rise) begin
      // Readback repeats the stored word, MSB first
      st_d.rb_bit = st_q.rb_shift[PSCR_TOTAL_BITS-1];
      st_d.rb_shift = {st_q.rb_shift[PSCR_TOTAL_BITS-2:0],
        st_q.rb_shift[PSCR_TOTAL_BITS-1]};
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode
  pscr_if cfg_bus();
  assign cfg_bus.coarse_clks = COARSE_BASE +
    {1'b0, delay_r[F_COARSE_LSB +: 2]};
  assign cfg_bus.fine_32nds = {1'b0, delay_r[F_FINE_LSB +: W_FINE]}
    + 7'h01;
  assign cfg_bus.sync_pol = pump_r[F_SYNC_POL];
  assign cfg_bus.delayed_hsync_out_pol = pump_r[F_DELAYED_HSYNC_OUT_POL];
  assign cfg_bus.tap_delay_sel = pump_r[F_TAPDLY];
  assign cfg_bus.tap_width_code = tp_r[F_WIDTH_LSB +: 2];
  assign cfg_bus.hold_mode = oe_r[F_HOLD];
  assign cfg_bus.src_sel = tp_r[F_SRC];
  assign cfg_bus.chip_en = tp_r[F_CHIP_EN];

  logic delayed_hsync_out_level;
  pscr_sync_path #(.MAX_DLY(8)) u_path (
    .sys_clk(sys_clk),
    .reset(reset),
    .cfg(cfg_bus),
    .sync_in_s(sync_s),
    .tap_in_s(tap_s),
    .coast_s(coast_s),
    .delayed_hsync_out_level(delayed_hsync_out_level)
  );

  assign divisor_value = div_decode(st_q.regs);
  assign divisor_in_range = (divisor_value >= 13'(DIV_OP_MIN)) &&
    (divisor_value <= 13'(DIV_OP_MAX));
  // Ratio 1,2,4,8 as a power-of-two shift of one
  assign post_div_ratio = 4'h1 << st_q.regs[P_CENFREQ +: W_CENFREQ];
  assign fine_delay_32nds = cfg_bus.fine_32nds;
  assign pump_current_code = pump_r[F_PUMP_LSB +: 2];
  assign phase_detector_sense = pump_r[F_PD_POL];
  assign chip_enable_bit = tp_r[F_CHIP_EN];
  assign oscillator_bypass_bit = tp_r[F_BYPASS];

  ////////////////////////////////////////////////////////////////////////////
  // Output gating
  logic en;
  logic full_src;
  assign en = tp_r[F_CHIP_EN];
  // Bypass cleared: counter tap drives the clock path for counter test
  assign full_src = tp_r[F_BYPASS] ? full_s : tap_s;
  assign readback_line = st_q.rb_bit;
  assign readback_line_oe_n = ~tp_r[F_SCAN];
  assign counter_tap_out = tap_s & en;
  assign counter_tap_out_oe_n = ~oe_r[F_OE_TAP];
  assign lock_loss_out = lock_s & en;
  assign lock_loss_out_oe_n = ~oe_r[F_OE_LOCK];
  assign delayed_hsync_out = delayed_hsync_out_level;
  assign delayed_hsync_out_oe_n = ~oe_r[F_OE_DELAYED_HSYNC_OUT];
  assign half_rate_clock_out = half_s & en;
  assign half_rate_clock_out_oe_n = ~oe_r[F_OE_HALF];
  assign half_rate_clock_out_inv = ~half_s & en;
  assign half_rate_clock_out_inv_oe_n = ~oe_r[F_OE_HALF_N];
  assign full_rate_clock_out = full_src & en;
  assign full_rate_clock_out_oe_n = ~oe_r[F_OE_FULL];
  assign full_rate_clock_out_inv = ~full_src & en;
  assign full_rate_clock_out_inv_oe_n = ~oe_r[F_OE_FULL_N];
  // Differential pairs ignore the output enables but are gated by chip enable
  assign diff_full_rate_p = full_src & en;
  assign diff_full_rate_n = ~(full_src & en);
  assign diff_half_rate_p = half_s & en;
  assign diff_half_rate_n = ~(half_s & en);
  assign diff_delayed_hsync_out_p = delayed_hsync_out_level;
  assign diff_delayed_hsync_out_n = ~delayed_hsync_out_level;
endmodule

// File: core/pscr_pkg.sv
// Package: register layout and field positions of the sync/clock control bank
package pscr_pkg;
  localparam int PSCR_NREG = 7;
  localparam int PSCR_TOTAL_BITS = 42;
  // Register widths, in shift order
  localparam int W_DIV_A = 8;
  localparam int W_DIV_B = 4;
  localparam int W_CENFREQ = 2;
  localparam int W_DELAY = 8;
  localparam int W_PUMP = 6;
  localparam int W_OEPOL = 8;
  localparam int W_TESTPOW = 6;
  // Bit positions inside the 42-bit shadow word (MSB shifted first)
  localparam int P_DIV_A = 34;
  localparam int P_DIV_B = 30;
  localparam int P_CENFREQ = 28;
  localparam int P_DELAY = 20;
  localparam int P_PUMP = 14;
  localparam int P_OEPOL = 6;
  localparam int P_TESTPOW = 0;
  // sync_delay_setting fields
  localparam int F_COARSE_LSB = 6;
  localparam int F_FINE_LSB = 0;
  localparam int W_FINE = 6;
  // pump_setting fields
  localparam int F_PUMP_LSB = 4;
  localparam int F_SYNC_POL = 3;
  localparam int F_DELAYED_HSYNC_OUT_POL = 2;
  localparam int F_PD_POL = 1;
  localparam int F_TAPDLY = 0;
  // output_enable_polarity fields (one enable per logic output)
  localparam int F_OE_TAP = 7;
  localparam int F_OE_LOCK = 6;
  localparam int F_OE_DELAYED_HSYNC_OUT = 5;
  localparam int F_OE_HALF = 4;
  localparam int F_OE_HALF_N = 3;
  localparam int F_OE_FULL = 2;
  localparam int F_OE_FULL_N = 1;
  // Hold-mode bit takes the spare slot; 42 bits leave no room elsewhere
  localparam int F_HOLD = 0;
  // test_power_control fields
  localparam int F_SCAN = 5;
  localparam int F_CHIP_EN = 4;
  localparam int F_BYPASS = 3;
  localparam int F_WIDTH_LSB = 0;
  localparam int F_SRC = 2;
  // Divisor limits
  localparam int DIV_FIELD_MIN = 9;
  localparam int DIV_FIELD_MAX = 4111;
  localparam int DIV_OP_MIN = 256;
  localparam int DIV_OP_MAX = 4096;
  localparam int DIV_OFFSET = 9;
  // Delay figures in clocks
  localparam logic [2:0] COARSE_BASE = 3'h2;
  localparam logic [2:0] TAP_DLY_OFF = 3'h4;
  localparam logic [2:0] TAP_DLY_ON = 3'h5;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage

// File: core/pscr_if.sv
// Interface: decoded control fields from the bank to the delay/output path
`timescale 1ns/1ps
interface pscr_if;
  logic [2:0] coarse_clks;
  logic [6:0] fine_32nds;
  logic sync_pol;
  logic delayed_hsync_out_pol;
  logic tap_delay_sel;
  logic [1:0] tap_width_code;
  logic hold_mode;
  logic src_sel;
  logic chip_en;
  modport bank(output coarse_clks, fine_32nds, sync_pol, delayed_hsync_out_pol,
    tap_delay_sel, tap_width_code, hold_mode, src_sel, chip_en);
  modport path(input coarse_clks, fine_32nds, sync_pol, delayed_hsync_out_pol,
    tap_delay_sel, tap_width_code, hold_mode, src_sel, chip_en);
endinterface

// File: core/pscr_sync_path.sv
// Delayed-sync output path: coarse delay, tap delay/width, hold, source
`timescale 1ns/1ps
module pscr_sync_path #(
  parameter int MAX_DLY = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Control fields
  pscr_if.path cfg,
  // Synchronised signals
  input wire logic sync_in_s,
  input wire logic tap_in_s,
  input wire logic coast_s,
  // Result
  output logic delayed_hsync_out_level
);
  import pscr_pkg::*;
  if (MAX_DLY < 8) begin : g_bad_depth
    $error("MAX_DLY too small");
  end
  typedef struct packed {
    logic [MAX_DLY-1:0] sync_sr;
    logic [MAX_DLY-1:0] tap_sr;
    logic [3:0] width_cnt;
    logic out;
  } pscr_path_t;
  pscr_path_t st_q, st_d;
  function automatic logic [3:0] width_clks(input logic [1:0] code);
    width_clks = 4'h1 << code;
  endfunction
  logic pol_sync;
  logic sel_sync;
  logic sel_tap_edge;
  logic [2:0] tap_dly;
  always_comb begin
    st_d = st_q;
    pol_sync = cfg.sync_pol ? sync_in_s : ~sync_in_s;
    st_d.sync_sr = {st_q.sync_sr[MAX_DLY-2:0], pol_sync};
    st_d.tap_sr = {st_q.tap_sr[MAX_DLY-2:0], tap_in_s};
    // Whole-clock part only; the fraction is left to the analog delay line
    // Output flop supplies the last clock of each delay
    sel_sync = st_q.sync_sr[cfg.coarse_clks - 3'h2];
    tap_dly = cfg.tap_delay_sel ? TAP_DLY_ON : TAP_DLY_OFF;
    sel_tap_edge = st_q.tap_sr[tap_dly - 3'h2] &
      ~st_q.tap_sr[tap_dly - 3'h1];
    if (sel_tap_edge) begin
      st_d.width_cnt = width_clks(cfg.tap_width_code);
    end else if (st_q.width_cnt != 4'h0) begin
      st_d.width_cnt = st_q.width_cnt - 4'h1;
    end
    st_d.out = cfg.src_sel ? sel_sync : (st_d.width_cnt != 4'h0);
    if (coast_s && !cfg.hold_mode) begin
      // Inactive level; the pin polarity is applied after the flop
      st_d.out = 1'b0;
    end
    if (!cfg.chip_en) begin
      st_d.out = 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign delayed_hsync_out_level = cfg.delayed_hsync_out_pol ? st_q.out : ~st_q.out;
endmodule

// File: sim/pscr_regs_properties.sv
// Checker: port-level properties of the serial control bank
`timescale 1ns/1ps
module pscr_regs_properties (
  // Clock and reset
  input logic sys_clk,
  input logic reset,
  // Serial bus
  input logic serial_clk,
  input logic load_window,
  input logic readback_line,
  // Decoded controls
  input logic [12:0] divisor_value,
  input logic divisor_in_range,
  input logic [3:0] post_div_ratio,
  input logic [6:0] fine_delay_32nds,
  input logic [1:0] pump_current_code,
  input logic chip_enable_bit,
  // Gated outputs
  input logic counter_tap_out,
  input logic lock_loss_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  a_div_span: assert property (divisor_value inside {[9:4111]})
    else $error("divisor outside field span");
  a_range_flag: assert property (divisor_in_range ==
    (divisor_value >= 256 && divisor_value <= 4096))
    else $error("range flag wrong");
  a_ratio_pow: assert property ($onehot(post_div_ratio))
    else $error("post divider not a power of two");
  a_fine_span: assert property (fine_delay_32nds inside {[1:64]})
    else $error("fine delay outside 1..64");
  a_chip_gate: assert property (!chip_enable_bit [*4] |->
    !counter_tap_out && !lock_loss_out)
    else $error("output active while chip disabled");
  // Eight cycles covers the sync delay of a window that just closed
  a_window_hold: assert property (load_window [*8] |->
    $stable(divisor_value) && $stable(post_div_ratio))
    else $error("register moved while window open");
  a_quiet_hold: assert property (!load_window [*8] |->
    $stable(pump_current_code) && $stable(chip_enable_bit))
    else $error("register moved with no window");
  a_rb_quiet: assert property ((!serial_clk && !load_window) [*8] |->
    $stable(readback_line))
    else $error("readback moved without serial edge");
  c_load: cover property ($fell(load_window));
  c_in_range: cover property (divisor_in_range);
  c_tap_on: cover property (chip_enable_bit && counter_tap_out);
endmodule
bind pscr_regs pscr_regs_properties u_pscr_regs_properties (.sys_clk,
  .reset, .serial_clk, .load_window, .readback_line, .divisor_value,
  .divisor_in_range, .post_div_ratio, .fine_delay_32nds, .pump_current_code,
  .chip_enable_bit, .counter_tap_out, .lock_loss_out);

// File: sim/pscr_host.sv
// Host model: drives the three-wire load bus and collects readback
`timescale 1ns/1ps
module pscr_host (
  // Clock
  input wire logic sys_clk,
  // Serial bus
  output logic serial_clk,
  output logic serial_in_bit,
  output logic load_window,
  input wire logic readback_line
);
  initial begin
    serial_clk = 1'b0;
    serial_in_bit = 1'b0;
    load_window = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Four clocks per phase clears the three-clock minimum after sync
  task automatic wr(input logic [41:0] w);
    load_window <= 1'b1;
    for (int i = 41; i >= 0; i--) begin
      tick(4);
      serial_in_bit <= w[i];
      tick(4);
      serial_clk <= 1'b1;
      tick(4);
      serial_clk <= 1'b0;
    end
    tick(4);
    load_window <= 1'b0;
    serial_in_bit <= ~w[0];
    tick(10);
  endtask
  // Window with no serial edges: the bank reloads what it already holds
  task automatic blip();
    load_window <= 1'b1;
    tick(8);
    load_window <= 1'b0;
    tick(10);
  endtask
  // Data line is not meaningful here, so it keeps toggling
  task automatic rd(output logic [41:0] w);
    for (int i = 41; i >= 0; i--) begin
      serial_in_bit <= ~serial_in_bit;
      serial_clk <= 1'b1;
      tick(6);
      w[i] = readback_line;
      serial_clk <= 1'b0;
      tick(4);
    end
  endtask
endmodule

// File: sim/pscr_regs_tb_top.sv
// Testbench: serial load, decoded controls and readback of the bank
`timescale 1ns/1ps
module pscr_regs_tb_top;
  import pscr_pkg::*;
  logic sys_clk, reset, serial_clk, serial_in_bit, load_window, coast;
  logic sync_in, counter_tap_in, lock_loss_in, full_rate_clk_in;
  logic half_rate_clk_in, readback_line, readback_line_oe_n;
  logic [12:0] divisor_value;
  logic [3:0] post_div_ratio;
  logic [6:0] fine_delay_32nds, oe_n;
  logic [1:0] pump_current_code;
  logic phase_detector_sense, chip_enable_bit, oscillator_bypass_bit;
  logic divisor_in_range, counter_tap_out, counter_tap_out_oe_n;
  logic lock_loss_out, lock_loss_out_oe_n, delayed_hsync_out;
  logic delayed_hsync_out_oe_n, half_rate_clock_out;
  logic half_rate_clock_out_oe_n, half_rate_clock_out_inv;
  logic half_rate_clock_out_inv_oe_n, full_rate_clock_out;
  logic full_rate_clock_out_oe_n, full_rate_clock_out_inv;
  logic full_rate_clock_out_inv_oe_n, diff_full_rate_p, diff_full_rate_n;
  logic diff_half_rate_p, diff_half_rate_n, diff_delayed_hsync_out_p, diff_delayed_hsync_out_n;
  int errors = 0;
  int n_checks = 0;
  assign oe_n = {counter_tap_out_oe_n, lock_loss_out_oe_n,
    delayed_hsync_out_oe_n, half_rate_clock_out_oe_n,
    half_rate_clock_out_inv_oe_n, full_rate_clock_out_oe_n,
    full_rate_clock_out_inv_oe_n};
  pscr_regs u_pscr_regs (.sys_clk, .reset, .serial_clk, .serial_in_bit,
    .load_window, .readback_line, .readback_line_oe_n, .sync_in,
    .counter_tap_in, .coast, .lock_loss_in, .full_rate_clk_in,
    .half_rate_clk_in, .divisor_value, .post_div_ratio, .fine_delay_32nds,
    .pump_current_code, .phase_detector_sense, .chip_enable_bit,
    .oscillator_bypass_bit, .divisor_in_range, .counter_tap_out,
    .counter_tap_out_oe_n, .lock_loss_out, .lock_loss_out_oe_n,
    .delayed_hsync_out, .delayed_hsync_out_oe_n, .half_rate_clock_out,
    .half_rate_clock_out_oe_n, .half_rate_clock_out_inv,
    .half_rate_clock_out_inv_oe_n, .full_rate_clock_out,
    .full_rate_clock_out_oe_n, .full_rate_clock_out_inv,
    .full_rate_clock_out_inv_oe_n, .diff_full_rate_p, .diff_full_rate_n,
    .diff_half_rate_p, .diff_half_rate_n, .diff_delayed_hsync_out_p, .diff_delayed_hsync_out_n);
  pscr_host u_pscr_host (.sys_clk, .serial_clk, .serial_in_bit,
    .load_window, .readback_line);
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    full_rate_clk_in <= ~full_rate_clk_in;
    half_rate_clk_in <= half_rate_clk_in ^ full_rate_clk_in;
  end
  task automatic chk(input logic [47:0] seen, exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [41:0] w, r;
    logic [1:0] pr;
    int raw[4] = '{246, 247, 4087, 4088};
    int fine[4] = '{7, 20, 33, 47};
    int ev;
    reset = 1'b1;
    {coast, sync_in, full_rate_clk_in, half_rate_clk_in} = 4'h0;
    // Inputs held high so gating by chip enable is visible
    {counter_tap_in, lock_loss_in} = 2'h3;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    chk(divisor_value, 9, "reset divisor");
    chk(chip_enable_bit, 0, "reset chip enable");
    chk(oe_n, 7'h7f, "reset enables");
    chk(post_div_ratio, 1, "reset ratio");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      // Polarity bits kept at one as a host normally does
      w = {raw[i][11:0], 2'(i), 2'(i), fine[i][5:0], 2'(i), 3'h7,
        1'(i), i[0] ? 8'haa : 8'h54, 1'h0, 1'(i), 1'(i >> 1), 3'h0};
      u_pscr_host.wr(w);
      ev = raw[i] + 9;
      chk(divisor_value, ev, "divisor");
      chk(divisor_in_range, ev >= 256 && ev <= 4096, "range flag");
      chk(post_div_ratio, 1 << i, "post divider");
      chk(fine_delay_32nds, fine[i] + 1, "fine delay");
      chk(pump_current_code, i, "pump code");
      chk(phase_detector_sense, 1, "detector sense");
      chk(chip_enable_bit, i & 1, "chip enable");
      chk(oscillator_bypass_bit, i >> 1, "bypass");
      chk(oe_n, 7'(~w[13:7]), "output enables");
      chk(counter_tap_out, i & 1, "tap gating");
      chk(lock_loss_out, i & 1, "lock gating");
      pr = {full_rate_clock_out | full_rate_clock_out_inv,
        half_rate_clock_out | half_rate_clock_out_inv};
      chk(pr, i[0] ? 2'h3 : 2'h0, "clock gating");
      pr = {diff_full_rate_p ^ diff_full_rate_n,
        diff_half_rate_p ^ diff_half_rate_n};
      chk(pr, 2'h3, "diff pairs");
      if (i == 1) begin
        // Steady tap input: a toggling clock here means bypass was ignored
        chk(full_rate_clock_out, 1, "tap test path");
        @(posedge sys_clk);
        chk(full_rate_clock_out, 1, "tap test path");
      end
      $display("test load %0d done", i);
    end
    w = {12'h3a5, 2'h2, 8'h47, 6'h2e, 8'h01, 6'h30};
    u_pscr_host.wr(w);
    chk(readback_line_oe_n, 0, "readback driven");
    u_pscr_host.rd(r);
    chk(r, w, "readback word");
    // Reload with no edges: any bit taken during readback would show here
    u_pscr_host.blip();
    chk(divisor_value, 12'h3a5 + 9, "edges outside window");
    $display("test readback done");
    // Delayed sync: coarse code 0 with hold off, code 3 with hold on
    for (int j = 0; j < 2; j++) begin
      w = {12'h3a5, 2'h0, 2'(3 * j), 6'h10, 6'h0e, 7'h7f, 1'(j), 6'h1c};
      u_pscr_host.wr(w);
      sync_in <= 1'b1;
      // Two synchroniser clocks, then two plus the coarse code
      for (int k = 1; k <= 4 + 3 * j; k++) begin
        @(posedge sys_clk);
        @(negedge sys_clk);
        chk(delayed_hsync_out, k == 4 + 3 * j, "sync delay");
      end
      pr = {diff_delayed_hsync_out_p, diff_delayed_hsync_out_n};
      chk(pr, 2'h2, "delayed_hsync_out pair");
      @(posedge sys_clk);
      coast <= 1'b1;
      repeat (8) @(posedge sys_clk);
      @(negedge sys_clk);
      chk(delayed_hsync_out, j, "coast hold");
      @(posedge sys_clk);
      {coast, sync_in} <= 2'h0;
      repeat (12) @(posedge sys_clk);
      $display("test sync delay %0d done", j);
    end
    complete_run();
  end
endmodule
